// ---- hw/aiq_pkg.sv ----
// Package of constants, types and register map for the acquisition sequencer
package aiq_pkg;
    localparam logic [7:0] AIQ_REG_CTRL = 8'h00;
    localparam logic [7:0] AIQ_REG_CMD = 8'h04;
    localparam logic [7:0] AIQ_REG_SAMPLE_IVL = 8'h08;
    localparam logic [7:0] AIQ_REG_SAMPLE_CNT = 8'h0C;
    localparam logic [7:0] AIQ_REG_SCAN_IVL = 8'h10;
    localparam logic [7:0] AIQ_REG_STATUS = 8'h14;
    localparam logic [7:0] AIQ_REG_EVENT = 8'h18;
    localparam logic [7:0] AIQ_REG_FIFO = 8'h1C;
    localparam logic [7:0] AIQ_REG_LEVEL = 8'h20;
    // Control field positions
    localparam int AIQ_CTRL_CH_LSB = 0;
    localparam int AIQ_CTRL_GAIN_LSB = 4;
    localparam int AIQ_CTRL_SCAN = 7;
    localparam int AIQ_CTRL_MODE_LSB = 8;
    localparam int AIQ_CTRL_EXT = 10;
    localparam int AIQ_CTRL_TWOS = 11;
    localparam int AIQ_CTRL_DIFF = 12;
    localparam int AIQ_CTRL_DITHER = 13;
    localparam int AIQ_CTRL_TRIG = 14;
    localparam int AIQ_CTRL_EVEN_LSB = 16;
    localparam int AIQ_CMD_START = 0;
    localparam int AIQ_CMD_STOP = 1;
    localparam int AIQ_CMD_CLR_OVF = 2;
    localparam logic [31:0] AIQ_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] AIQ_IVL_RST = 16'h01F4;
    localparam logic [15:0] AIQ_CNT_RST = 16'h0001;
    localparam logic [15:0] AIQ_SCAN_RST = 16'h0FA0;
    localparam int AIQ_CLK_MHZ = 50;
    localparam int AIQ_CONV_US = 10;
    localparam int AIQ_CONV_CYC = AIQ_CONV_US * AIQ_CLK_MHZ;
    localparam int AIQ_FIFO_DEPTH = 512;
    localparam int AIQ_FIFO_AW = 9;
    localparam logic [2:0] AIQ_GAIN_MAX = 3'h6;

    typedef enum logic [1:0] {
        AIQ_CONTROLLED = 2'b00,
        AIQ_FREERUN = 2'b01,
        AIQ_INTERVAL = 2'b11
    } aiq_mode_e;

    typedef enum logic [1:0] {
        AIQ_IDLE = 2'b00,
        AIQ_WAIT = 2'b01,
        AIQ_RUN = 2'b11,
        AIQ_PAUSE = 2'b10
    } aiq_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } aiq_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } aiq_apb_rsp_s;

    typedef struct packed {
        logic [2:0] chan;
        logic [2:0] chan_pair;
        logic diff;
        logic [2:0] gain;
        logic dither;
        logic convert;
    } aiq_front_s;
endpackage

// ---- hw/aiq_sequencer.sv ----
// Acquisition sequencer: mux counting, timing counters, result FIFO, APB
`timescale 1ns/1ps
module aiq_sequencer #(
    parameter int FIFO_AW = aiq_pkg::AIQ_FIFO_AW,
    parameter int CONV_CYC = aiq_pkg::AIQ_CONV_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register bus
    input wire aiq_pkg::aiq_apb_req_s apb_req,
    output aiq_pkg::aiq_apb_rsp_s apb_rsp,
    // External timing pins
    input wire logic external_acq_trigger,
    input wire logic external_convert_strobe_n,
    // Converter
    input wire logic adc_done,
    input wire logic [11:0] adc_code,
    output aiq_pkg::aiq_front_s front,
    output logic acq_active
);
    import aiq_pkg::*;

    localparam int DEPTH = 1 << FIFO_AW;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] ivl_load;
        logic [15:0] cnt_load;
        logic [15:0] scan_load;
        logic [15:0] ivl_ctr;
        logic [15:0] cnt_ctr;
        logic [15:0] scan_ctr;
        logic [15:0] conv_ctr;
        logic [2:0] chan;
        logic [2:0] hold_gain;
        aiq_state_e state;
        logic [FIFO_AW-1:0] wr_ptr;
        logic [FIFO_AW-1:0] rd_ptr;
        logic [FIFO_AW:0] level;
        logic [15:0] rd_word;
        logic [3:0] events;
        logic convert;
        logic busy;
        logic [1:0] trig_sync;
        logic trig_last;
        logic [1:0] conv_sync;
        logic conv_last;
        logic [31:0] prdata;
        logic [15:0] push_word;
        logic push;
    } aiq_state_s;

    aiq_state_s cur, next_cur;
    logic [15:0] fifo_mem [DEPTH];
    logic wr_en, rd_en, ready, trig_edge, conv_edge, tick, sw_start, sw_stop;
    logic full, start, conv_req, last_done;
    aiq_mode_e mode;
    logic [15:0] ext_word;

    assign ready = apb_req.psel && apb_req.penable;
    assign wr_en = ready && apb_req.pwrite;
    assign rd_en = ready && !apb_req.pwrite;
    assign mode = aiq_mode_e'(cur.ctrl[AIQ_CTRL_MODE_LSB +: 2]);
    assign full = cur.level == (FIFO_AW+1)'(DEPTH);
    assign trig_edge = cur.trig_sync[1] && !cur.trig_last;
    // Strobe is active low: falling edge asks for one conversion
    assign conv_edge = !cur.conv_sync[1] && cur.conv_last;
    assign sw_start = wr_en && apb_req.paddr == AIQ_REG_CMD &&
        apb_req.pwdata[AIQ_CMD_START];
    assign sw_stop = wr_en && apb_req.paddr == AIQ_REG_CMD &&
        apb_req.pwdata[AIQ_CMD_STOP];
    // Start by software or by the rising trigger when armed
    assign start = sw_start ||
        (cur.ctrl[AIQ_CTRL_TRIG] && trig_edge);
    // Sign extension by coding
    assign ext_word = cur.ctrl[AIQ_CTRL_TWOS] ?
        {{4{adc_code[11]}}, adc_code} :
        {4'h0, adc_code};

    always_comb begin
        next_cur = cur;
        tick = 1'b0;
        conv_req = 1'b0;
        last_done = 1'b0;
        next_cur.trig_sync = {cur.trig_sync[0], external_acq_trigger};
        next_cur.trig_last = cur.trig_sync[1];
        next_cur.conv_sync = {cur.conv_sync[0], external_convert_strobe_n};
        next_cur.conv_last = cur.conv_sync[1];
        next_cur.convert = 1'b0;
        next_cur.push = 1'b0;
        // Control, interval and count registers writable only while idle so settings hold
        if (wr_en && cur.state == AIQ_IDLE) begin
            case (apb_req.paddr)
                AIQ_REG_CTRL: begin
                    next_cur.ctrl = apb_req.pwdata & 32'h000F_7FF7;
                    if (apb_req.pwdata[AIQ_CTRL_GAIN_LSB +: 3] > AIQ_GAIN_MAX) begin
                        next_cur.ctrl[AIQ_CTRL_GAIN_LSB +: 3] = AIQ_GAIN_MAX;
                    end
                end
                AIQ_REG_SAMPLE_IVL: next_cur.ivl_load = apb_req.pwdata[15:0];
                AIQ_REG_SAMPLE_CNT: next_cur.cnt_load = apb_req.pwdata[15:0];
                AIQ_REG_SCAN_IVL: next_cur.scan_load = apb_req.pwdata[15:0];
                default: ;
            endcase
        end
        // Sample interval counter decrements while gated
        if (cur.state == AIQ_RUN || cur.state == AIQ_WAIT) begin
            if (cur.ivl_ctr <= 16'h0001) begin
                next_cur.ivl_ctr = cur.ivl_load;
                tick = 1'b1;
            end else begin
                next_cur.ivl_ctr = cur.ivl_ctr - 16'h0001;
            end
        end
        // Scan interval counter runs free during interval mode
        if (cur.state != AIQ_IDLE && mode == AIQ_INTERVAL) begin
            if (cur.scan_ctr <= 16'h0001) begin
                next_cur.scan_ctr = cur.scan_load;
                next_cur.state = AIQ_WAIT;
                next_cur.ivl_ctr = cur.ivl_load;
                next_cur.chan = cur.ctrl[AIQ_CTRL_CH_LSB +: 3];
            end else begin
                next_cur.scan_ctr = cur.scan_ctr - 16'h0001;
            end
        end
        case (cur.state)
            AIQ_IDLE: begin
                if (start) begin
                    next_cur.state = mode == AIQ_INTERVAL ? AIQ_WAIT : AIQ_RUN;
                    next_cur.ivl_ctr = cur.ivl_load;
                    next_cur.cnt_ctr = cur.cnt_load;
                    next_cur.scan_ctr = cur.scan_load;
                    next_cur.chan = cur.ctrl[AIQ_CTRL_CH_LSB +: 3];
                    next_cur.hold_gain = cur.ctrl[AIQ_CTRL_GAIN_LSB +: 3];
                end
            end
            AIQ_WAIT: begin
                // One full interval, then the first channel converts
                if (tick) begin
                    next_cur.state = AIQ_RUN;
                    conv_req = !cur.ctrl[AIQ_CTRL_EXT];
                end
            end
            AIQ_RUN: begin
                // External strobe or internal interval paces
                conv_req = cur.ctrl[AIQ_CTRL_EXT] ? conv_edge : tick;
            end
            AIQ_PAUSE: ;
            default: next_cur.state = AIQ_IDLE;
        endcase
        if (conv_req && !cur.busy) begin
            next_cur.convert = 1'b1;
            next_cur.busy = 1'b1;
            next_cur.conv_ctr = 16'(CONV_CYC);
            if (mode == AIQ_CONTROLLED) begin
                next_cur.cnt_ctr = cur.cnt_ctr - 16'h0001;
                // Count expiry gates off the interval counter
                if (cur.cnt_ctr <= 16'h0001) begin
                    next_cur.state = AIQ_IDLE;
                    last_done = 1'b1;
                end
            end
            if (cur.ctrl[AIQ_CTRL_SCAN] && cur.chan == 3'h0 &&
                mode == AIQ_INTERVAL) begin
                next_cur.state = AIQ_PAUSE;
            end
        end
        // Mux steps after the pulse so each conversion sees its channel
        if (cur.convert && cur.ctrl[AIQ_CTRL_SCAN]) begin
            // Decrement, reload after channel 0
            if (cur.chan == 3'h0) begin
                next_cur.chan = cur.ctrl[AIQ_CTRL_CH_LSB +: 3];
            end else begin
                next_cur.chan = cur.chan - 3'h1;
            end
        end
        if (cur.busy) begin
            next_cur.conv_ctr = cur.conv_ctr - 16'h0001;
            if (cur.conv_ctr <= 16'h0001) begin
                next_cur.busy = 1'b0;
            end
        end
        // Software ends freerun or any mode
        if (sw_stop && cur.state != AIQ_IDLE) begin
            next_cur.state = AIQ_IDLE;
            last_done = 1'b1;
        end
        // Converter results land in FIFO with no software help
        if (adc_done) begin
            next_cur.push_word = ext_word;
            next_cur.push = 1'b1;
        end
        // Read pops the oldest entry
        if (rd_en && apb_req.paddr == AIQ_REG_FIFO && cur.level != '0) begin
            next_cur.rd_ptr = cur.rd_ptr + 1'b1;
            next_cur.level = cur.level - 1'b1;
        end
        if (cur.push) begin
            if (full) begin
                next_cur.events[3] = 1'b1;
            end else begin
                next_cur.wr_ptr = cur.wr_ptr + 1'b1;
                next_cur.level = next_cur.level + 1'b1;
            end
        end
        // Event clear: write one to clear; a new set wins
        if (wr_en && apb_req.paddr == AIQ_REG_EVENT) begin
            next_cur.events = cur.events & ~apb_req.pwdata[3:0];
        end
        if (wr_en && apb_req.paddr == AIQ_REG_CMD &&
            apb_req.pwdata[AIQ_CMD_CLR_OVF]) begin
            next_cur.events[3] = 1'b0;
        end
        if (cur.push && !full) begin
            next_cur.events[0] = 1'b1;
        end
        if (cur.push && cur.level == (FIFO_AW+1)'(DEPTH / 2 - 1)) begin
            next_cur.events[1] = 1'b1;
        end
        if (last_done) begin
            next_cur.events[2] = 1'b1;
        end
        if (cur.push && full) begin
            next_cur.events[3] = 1'b1;
        end
        next_cur.rd_word = fifo_mem[next_cur.rd_ptr];
        next_cur.prdata = 32'h0000_0000;
        case (apb_req.paddr)
            AIQ_REG_CTRL: next_cur.prdata = cur.ctrl;
            AIQ_REG_SAMPLE_IVL: next_cur.prdata = {16'h0000, cur.ivl_load};
            AIQ_REG_SAMPLE_CNT: next_cur.prdata = {16'h0000, cur.cnt_load};
            AIQ_REG_SCAN_IVL: next_cur.prdata = {16'h0000, cur.scan_load};
            AIQ_REG_STATUS: next_cur.prdata = {23'h00_0000, cur.busy,
                cur.state, cur.chan, cur.level == '0, full, cur.state != AIQ_IDLE};
            AIQ_REG_EVENT: next_cur.prdata = {28'h000_0000, cur.events};
            AIQ_REG_FIFO: next_cur.prdata = {16'h0000, cur.rd_word};
            AIQ_REG_LEVEL: next_cur.prdata = 32'(cur.level);
            default: ;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cur <= '0;
            cur.ctrl <= AIQ_CTRL_RST;
            cur.ivl_load <= AIQ_IVL_RST;
            cur.cnt_load <= AIQ_CNT_RST;
            cur.scan_load <= AIQ_SCAN_RST;
            cur.state <= AIQ_IDLE;
            cur.trig_last <= 1'b0;
            cur.conv_sync <= 2'b11;
            cur.conv_last <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    always_ff @(posedge mclk) begin
        if (cur.push && !full) begin
            fifo_mem[cur.wr_ptr] <= cur.push_word;
        end
    end

    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = 1'b0;
    assign apb_rsp.prdata = cur.prdata;
    // Differential pairs odd channel with the second mux
    assign front.chan = cur.chan;
    assign front.chan_pair = {cur.chan[2:1], 1'b1};
    assign front.diff = cur.ctrl[AIQ_CTRL_DIFF];
    assign front.gain = cur.state == AIQ_IDLE ?
        cur.ctrl[AIQ_CTRL_GAIN_LSB +: 3] : cur.hold_gain;
    assign front.dither = cur.ctrl[AIQ_CTRL_DITHER];
    assign front.convert = cur.convert;
    assign acq_active = cur.state != AIQ_IDLE;
endmodule

// ---- testbench/aiq_adc_model.sv ----
// Converter model: busy for four cycles less than the conversion time, then one result pulse
`timescale 1ns/1ps
module aiq_adc_model #(
    parameter int CONV_CYC = 500
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Front end
    input wire aiq_pkg::aiq_front_s front,
    output logic adc_done,
    output logic [11:0] adc_code
);
    int cnt;
    logic [2:0] held_chan;

    // Result is {channel, 9'h155}; outside the done cycle the bus toggles
    always_ff @(posedge mclk) begin
        adc_done <= 1'b0;
        if (srst) begin
            cnt <= 0;
            held_chan <= 3'h0;
            adc_code <= 12'h000;
        end else if (front.convert) begin
            cnt <= CONV_CYC - 4;
            held_chan <= front.chan;
            adc_code <= ~adc_code;
        end else if (cnt == 1) begin
            cnt <= 0;
            adc_done <= 1'b1;
            adc_code <= {held_chan, 9'h155};
        end else begin
            if (cnt != 0) begin
                cnt <= cnt - 1;
            end
            adc_code <= ~adc_code;
        end
    end
endmodule

// ---- testbench/aiq_checker.sv ----
// Concurrent checks on the acquisition sequencer ports
`timescale 1ns/1ps
module aiq_checker
    import aiq_pkg::*;
#(
    parameter int FIFO_AW = 9,
    parameter int CONV_CYC = 500
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register bus
    input wire aiq_pkg::aiq_apb_req_s apb_req,
    // Front end
    input wire aiq_pkg::aiq_front_s front,
    input wire logic acq_active
);
    logic [15:0] ctrl_copy;
    logic [15:0] gap;

    default clocking @(posedge mclk);
    endclocking
    default disable iff (srst);

    // Control copy follows only writes that the block accepts
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_copy <= 16'h0000;
        end else if (apb_req.psel && apb_req.penable && apb_req.pwrite &&
                     apb_req.paddr == AIQ_REG_CTRL && !acq_active) begin
            ctrl_copy <= apb_req.pwdata[15:0];
        end
    end

    // Cycles since the last conversion start
    always_ff @(posedge mclk) begin
        if (srst) begin
            gap <= 16'(CONV_CYC);
        end else if (front.convert) begin
            gap <= 16'h0000;
        end else if (gap != 16'hFFFF) begin
            gap <= gap + 16'h0001;
        end
    end

    chk_gain_range: assert property (front.gain <= 3'h6)
        else $error("gain code out of range");
    chk_gain_held: assert property (
        acq_active && $past(acq_active) |-> $stable(front.gain))
        else $error("gain moved during acquisition");
    chk_chan_single: assert property (
        acq_active && $past(acq_active) && !ctrl_copy[AIQ_CTRL_SCAN]
        |-> $stable(front.chan))
        else $error("channel moved in single mode");
    chk_chan_dec: assert property (
        acq_active && $past(acq_active) && ctrl_copy[AIQ_CTRL_SCAN] &&
        $changed(front.chan) |-> front.chan == (($past(front.chan) == 3'h0)
        ? ctrl_copy[2:0] : $past(front.chan) - 3'h1))
        else $error("scan channel step wrong");
    chk_pair_odd: assert property (
        front.chan_pair == {front.chan[2:1], 1'b1})
        else $error("paired channel not odd partner");
    chk_conv_pulse: assert property (front.convert |=> !front.convert)
        else $error("convert pulse longer than one cycle");
    chk_conv_active: assert property (
        front.convert |-> acq_active || $past(acq_active))
        else $error("convert outside acquisition");
    chk_conv_space: assert property (
        front.convert |-> gap >= 16'(CONV_CYC - 1))
        else $error("convert during busy converter");
endmodule

bind aiq_sequencer aiq_checker #(
    .FIFO_AW(FIFO_AW),
    .CONV_CYC(CONV_CYC)
) i_chk (
    .mclk(mclk),
    .srst(srst),
    .apb_req(apb_req),
    .front(front),
    .acq_active(acq_active)
);

// ---- testbench/tb.sv ----
// Testbench for the acquisition sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
err_total++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb;
    import aiq_pkg::*;
    logic mclk = 0, srst = 1, trig = 0, strobe_n = 1, adc_done;
    logic acq_active;
    logic [11:0] adc_code;
    logic [31:0] rd;
    aiq_apb_req_s req = '0;
    aiq_apb_rsp_s rsp;
    aiq_front_s front;
    int err_total = 0, samples_checked = 0, n_conv = 0, cyc = 0, t0, g;
    int act_t = 0;
    logic act_q = 1'b0;
    int conv_t[$];
    logic [11:0] scan_exp[5] = '{12'h555, 12'h355, 12'h155, 12'h555, 12'h355};

    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (front.convert === 1'b1) begin
            n_conv++;
            conv_t.push_back(cyc);
        end
        if (acq_active === 1'b1 && act_q !== 1'b1) act_t = cyc;
        act_q = acq_active;
    end

    aiq_sequencer #(.FIFO_AW(3), .CONV_CYC(20)) i_dut (.mclk(mclk),
        .srst(srst), .apb_req(req), .apb_rsp(rsp),
        .external_acq_trigger(trig), .external_convert_strobe_n(strobe_n),
        .adc_done(adc_done), .adc_code(adc_code), .front(front),
        .acq_active(acq_active));
    aiq_adc_model #(.CONV_CYC(20)) i_adc (.mclk(mclk), .srst(srst),
        .front(front), .adc_done(adc_done), .adc_code(adc_code));

    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge mclk);
        req.penable <= 1'b1;
        // Read data is taken at the same edge that sees pready high
        for (k = 0; k < 50; k++) begin
            @(posedge mclk);
            if (rsp.pready === 1'b1) begin
                rd = rsp.prdata;
                break;
            end
        end
        if (k == 50) begin
            err_total++;
            end_of_test();
        end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask
    task fifo_chk(input logic [15:0] e);
        bus(1'b0, AIQ_REG_FIFO, 32'h0000_0000);
        `CHK(rd[15:0], e)
    endtask
    task wait_conv(input int n);
        int k;
        for (k = 0; k < 5000 && n_conv < n; k++) @(posedge mclk);
        if (k == 5000) begin
            err_total++;
            end_of_test();
        end
    endtask
    task wait_idle;
        int k;
        for (k = 0; k < 5000 && acq_active !== 1'b0; k++) @(posedge mclk);
        if (k == 5000) begin
            err_total++;
            end_of_test();
        end
        repeat (30) @(posedge mclk);
    endtask
    task drain(input string s);
        int k;
        for (k = 0; k < 40; k++) begin
            bus(1'b0, AIQ_REG_LEVEL, 32'h0000_0000);
            if (rd == 0) break;
            bus(1'b0, AIQ_REG_FIFO, 32'h0000_0000);
        end
        $display("test %s done", s);
    endtask
    task start(input logic [31:0] ctrl);
        bus(1'b1, AIQ_REG_CTRL, ctrl);
        t0 = n_conv;
        bus(1'b1, AIQ_REG_CMD, 32'h0000_0001);
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        rdc(AIQ_REG_CTRL, AIQ_CTRL_RST);
        rdc(AIQ_REG_SAMPLE_IVL, {16'h0000, AIQ_IVL_RST});
        rdc(AIQ_REG_SAMPLE_CNT, {16'h0000, AIQ_CNT_RST});
        rdc(AIQ_REG_SCAN_IVL, {16'h0000, AIQ_SCAN_RST});
        rdc(8'h24, 32'h0000_0000);
        for (g = 0; g < 8; g++) begin
            bus(1'b1, AIQ_REG_CTRL, 32'h0000_3000 | (g << 4));
            repeat (2) @(posedge mclk);
            `CHK(front.gain, (g > 6) ? 3'h6 : 3'(g))
        end
        `CHK({front.diff, front.dither, front.chan_pair}, 5'h19)
        drain("config");
        // Controlled single channel, two's complement, gain clamped
        bus(1'b1, AIQ_REG_SAMPLE_IVL, 32'h0000_0018);
        bus(1'b1, AIQ_REG_SAMPLE_CNT, 32'h0000_0003);
        start(32'h0000_0875);
        wait_conv(t0 + 1);
        `CHK(front.gain, 3'h6)
        wait_idle();
        `CHK(n_conv - t0, 3)
        rdc(AIQ_REG_LEVEL, 32'h0000_0003);
        fifo_chk(16'hFB55);
        bus(1'b0, AIQ_REG_EVENT, 32'h0000_0000);
        `CHK(rd[2], 1'b1)
        bus(1'b1, AIQ_REG_EVENT, 32'h0000_000F);
        drain("controlled");
        // Freerun scan from channel 2, write refused while running
        start(32'h0000_0192);
        wait_conv(t0 + 5);
        bus(1'b1, AIQ_REG_CTRL, 32'h0000_0197);
        rdc(AIQ_REG_CTRL, 32'h0000_0192);
        bus(1'b1, AIQ_REG_CMD, 32'h0000_0002);
        wait_idle();
        for (g = 0; g < 5; g++) fifo_chk({4'h0, scan_exp[g]});
        drain("freerun scan");
        // Overflow: ten results into an eight entry buffer
        bus(1'b1, AIQ_REG_SAMPLE_CNT, 32'h0000_000A);
        start(32'h0000_0003);
        wait_conv(t0 + 1);
        wait_idle();
        rdc(AIQ_REG_LEVEL, 32'h0000_0008);
        bus(1'b0, AIQ_REG_STATUS, 32'h0000_0000);
        `CHK(rd[1], 1'b1)
        bus(1'b0, AIQ_REG_EVENT, 32'h0000_0000);
        `CHK(rd[3], 1'b1)
        bus(1'b1, AIQ_REG_CMD, 32'h0000_0004);
        bus(1'b0, AIQ_REG_EVENT, 32'h0000_0000);
        `CHK(rd[3], 1'b0)
        fifo_chk(16'h0755);
        drain("overflow");
        // Interval scanning: sample and scan periods
        bus(1'b1, AIQ_REG_SCAN_IVL, 32'h0000_00C8);
        conv_t.delete();
        start(32'h0000_0381);
        wait_conv(t0 + 3);
        bus(1'b1, AIQ_REG_CMD, 32'h0000_0002);
        wait_idle();
        `CHK(conv_t[1] - conv_t[0], 24)
        `CHK(conv_t[2] - conv_t[0], 200)
        `CHK(conv_t[0] - act_t, 24)
        drain("interval");
        // External convert strobe, one strobe per pair lands while busy
        start(32'h0000_0504);
        @(posedge mclk);
        `CHK(front.chan_pair, 3'h5)
        for (g = 0; g < 3; g++) begin
            strobe_n <= 1'b0;
            repeat (2) @(posedge mclk);
            strobe_n <= 1'b1;
            repeat (5) @(posedge mclk);
            strobe_n <= 1'b0;
            repeat (2) @(posedge mclk);
            strobe_n <= 1'b1;
            repeat (40) @(posedge mclk);
        end
        `CHK(n_conv - t0, 3)
        bus(1'b1, AIQ_REG_CMD, 32'h0000_0002);
        wait_idle();
        fifo_chk(16'h0955);
        drain("external convert");
        // Armed external trigger starts a controlled run
        bus(1'b1, AIQ_REG_SAMPLE_CNT, 32'h0000_0002);
        bus(1'b1, AIQ_REG_CTRL, 32'h0000_4000);
        t0 = n_conv;
        trig <= 1'b1;
        repeat (3) @(posedge mclk);
        trig <= 1'b0;
        wait_conv(t0 + 2);
        wait_idle();
        `CHK(n_conv - t0, 2)
        drain("trigger");
        end_of_test();
    end
endmodule
